// File: bench/sfb_cpu_model.sv
// cpu side of the sfr port: one access at a time
// assumes calls start just after a rising clock edge
`timescale 1ns/1ps
module sfb_cpu_model import sfb_pkg::*; (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [15:0] rdata_i,
  output logic req_o,
  output logic we_o,
  output sfb_op_t op_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o
);
  initial begin
    {req_o, we_o, addr_o, wdata_o} = '0;
    op_o = SFB_OP_WORD;
  end
  task automatic acc(input logic w, input sfb_op_t op, input logic [15:0] a, d,
    output logic [15:0] rd);
    {req_o, we_o, addr_o, wdata_o} = {1'b1, w, a, d};
    op_o = op;
    @(posedge clk_i);
    #1 req_o = 0;
    // released lines must not keep their last value
    {we_o, addr_o, wdata_o} = ~{w, a, d};
    // ack and read data stand for the cycle after the taking edge
    rd = (ack_i === 1'b1) ? rdata_i : 'x;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// File: bench/sfb_register_bank_chk.sv
// port assertions of the sfr bank
// assumes binding into the bank, one clock domain
`timescale 1ns/1ps
module sfb_register_bank_chk import sfb_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire sfb_op_t op_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic ready_o,
  input wire logic ack_o,
  input wire logic [15:0] rdata_o,
  input wire logic [6:0] port_four_data_o,
  input wire logic [7:0] port_eight_data_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire tk = ce_i && req_i && ready_o;
  wire rdw = tk && !we_i && op_i == SFB_OP_WORD;
  wire wrw = tk && we_i && op_i == SFB_OP_WORD;
  taken_ack_a: assert property (tk |=> ack_o)
    else $error("no ack");
  lone_ack_a: assert property (ack_o |-> $past(tk))
    else $error("stray ack");
  zero_read_a: assert property (rdw && addr_i == ALL_LOW_OFF |=> rdata_o == ALL_LOW_VAL)
    else $error("zero reg");
  all_high_constant_read_a: assert property (rdw && addr_i == ALL_HIGH_OFF |=> rdata_o == ALL_HIGH_VAL)
    else $error("all_high_constant reg");
  byte_upper_a: assert property (tk && !we_i && op_i == SFB_OP_BYTE |=> rdata_o[15:8] == 8'h00)
    else $error("byte read upper");
  ready_hold_a: assert property (ready_o |=> ready_o)
    else $error("ready dropped");
  p8_copy_a: assert property (wrw && addr_i == 16'hffd4 |-> ##3
    port_eight_data_o == $past(wdata_i[7:0], 3)) else $error("port eight");
  p4_copy_a: assert property (wrw && addr_i == 16'hffc8 |-> ##3
    port_four_data_o == $past(wdata_i[6:0], 3)) else $error("port four");
  c_byte: cover property (tk && we_i && op_i == SFB_OP_BYTE);
  c_bit: cover property (tk && op_i == SFB_OP_BCLR);
  c_all_high_constant: cover property (ack_o && rdata_o == ALL_HIGH_VAL);
endmodule
bind sfb_register_bank sfb_register_bank_chk i_chk (.*);

// File: bench/sfb_register_bank_tb.sv
// self-checking bench of the sfr bank
// assumes the cpu model drives every access
`timescale 1ns/1ps
module sfb_register_bank_tb;
  import sfb_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, req_i, we_i, ready_o, ack_o;
  sfb_op_t op_i;
  logic [15:0] addr_i, wdata_i, rdata_o, rd, system_configuration_o, watchdog_control_o;
  logic [15:0] analog_pins_i = 16'h5a3c;
  logic [1:0] gpr_bank_i = 2'h1;
  logic [7:0] startup_cfg_i = 8'ha5, reset_source_i = 8'h0c, port_eight_data_o;
  logic [6:0] port_four_data_o;
  int err_count = 0, tests_run = 0, cyc = 0;
  localparam logic [15:0] ra [8] = '{16'hff30, 16'hff32, 16'hff1c, 16'hff1e,
    16'hff14, 16'hffc8, 16'hffd4, 16'hff50};
  localparam logic [15:0] rv [8] = '{16'h1010, 16'h00ff, 16'h0000, 16'hffff,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  initial forever #2 ref_clk_i = ~ref_clk_i;
  sfb_register_bank i_dut (.*, .ce_i(1'b1), .bit_i(wdata_i[3:0]));
  sfb_cpu_model i_cpu (.clk_i(ref_clk_i), .ack_i(ack_o), .rdata_i(rdata_o), .req_o(req_i),
    .we_o(we_i), .op_o(op_i), .addr_o(addr_i), .wdata_o(wdata_i));
  task automatic chk(input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input sfb_op_t o, input logic [15:0] a, d);
    i_cpu.acc(1, o, a, d, rd);
  endtask
  task automatic rdc(input sfb_op_t o, input logic [15:0] a, e);
    i_cpu.acc(0, o, a, 16'h0, rd);
    chk(rd, e);
  endtask
  task automatic do_reset();
    rst_n_i = 0;
    repeat (8) @(posedge ref_clk_i);
    #1 rst_n_i = 1;
    for (int i = 0; i < 20 && ready_o !== 1'b1; i++) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk_rst();
    rdc(SFB_OP_WORD, 16'hff12, {4'h0, startup_cfg_i, 4'h0});
    rdc(SFB_OP_WORD, 16'hffae, {8'h00, reset_source_i});
    foreach (ra[i]) rdc(SFB_OP_WORD, ra[i], rv[i]);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    do_reset();
    chk_rst();
    wr(SFB_OP_WORD, 16'hff1c, 16'hffff);
    wr(SFB_OP_WORD, 16'hff1e, 16'h0000);
    rdc(SFB_OP_WORD, 16'hff1c, 16'h0000);
    rdc(SFB_OP_WORD, 16'hff1e, 16'hffff);
    wr(SFB_OP_WORD, 16'hff14, 16'h1234);
    rdc(SFB_OP_BYTE, 16'hff15, 16'h0012);
    rdc(SFB_OP_BYTE, 16'hff14, 16'h0034);
    rdc(SFB_OP_WORD, 16'hff14, 16'h1234);
    wr(SFB_OP_BYTE, 16'hff15, 16'h00ab);
    rdc(SFB_OP_WORD, 16'hff14, 16'hab00);
    wr(SFB_OP_BSET, 16'hff16, 16'h0003);
    wr(SFB_OP_BSET, 16'hff16, 16'h000f);
    rdc(SFB_OP_WORD, 16'hff16, 16'h8008);
    wr(SFB_OP_BCLR, 16'hff16, 16'h0003);
    rdc(SFB_OP_WORD, 16'hff16, 16'h8000);
    wr(SFB_OP_WORD, 16'hffc8, 16'hffff);
    wr(SFB_OP_WORD, 16'hffd4, 16'hffff);
    rdc(SFB_OP_WORD, 16'hffc8, 16'h007f);
    rdc(SFB_OP_WORD, 16'hffd4, 16'h00ff);
    chk({9'h000, port_four_data_o}, 16'h007f);
    chk({8'h00, port_eight_data_o}, 16'h00ff);
    wr(SFB_OP_WORD, 16'hffa2, 16'h0000);
    rdc(SFB_OP_WORD, 16'hffa2, 16'h5a3c);
    wr(SFB_OP_WORD, 16'hf004, 16'hbeef);
    gpr_bank_i = 2'h2;
    wr(SFB_OP_WORD, 16'hf004, 16'h1111);
    gpr_bank_i = 2'h1;
    rdc(SFB_OP_WORD, 16'hf004, 16'hbeef);
    wr(SFB_OP_WORD, 16'hfce0, 16'hcafe);
    wr(SFB_OP_BYTE, 16'hfce1, 16'h0077);
    startup_cfg_i = 8'h3c;
    reset_source_i = 8'h05;
    do_reset();
    chk_rst();
    rdc(SFB_OP_WORD, 16'hfce0, 16'h77fe);
    give_verdict();
  end
endmodule

// File: hdl/sfb_pkg.sv
// constants, register map and types of the upper sfr register bank
// assumes a 16-bit cpu sfr port on one clock
package sfb_pkg;

  localparam int NREG = 45;
  localparam int GPR_WORDS = 16;
  localparam int PEC_WORDS = 16;

  typedef enum logic [1:0] {
    SFB_OP_WORD = 2'h0,
    SFB_OP_BYTE = 2'h1,
    SFB_OP_BSET = 2'h2,
    SFB_OP_BCLR = 2'h3
  } sfb_op_t;

  localparam logic [15:0] ALL_LOW_OFF = 16'hff1c;
  localparam logic [15:0] ALL_HIGH_OFF = 16'hff1e;
  localparam logic [15:0] ALL_LOW_VAL = 16'h0000;
  localparam logic [15:0] ALL_HIGH_VAL = 16'hffff;
  localparam logic [15:0] ANALOG_PORT_IN_OFF = 16'hffa2;
  localparam logic [15:0] GPR_MIRROR_BASE = 16'hf000;
  localparam logic [15:0] PEC_PTR_BASE = 16'hfce0;

  localparam int SYSTEM_CONFIGURATION_IDX = 0;
  localparam int WATCHDOG_CONTROL_IDX = 36;
  localparam int PORT4_IDX = 41;
  localparam int PORT8_IDX = 43;
  localparam int SYSTEM_CONFIGURATION_CFG_LSB = 4;
  localparam int WDT_SRC_LSB = 0;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  localparam logic [15:0] REG_OFF [NREG] = '{
    16'hff12, 16'hff14, 16'hff16, 16'hff18, 16'hff1a,
    16'hff20, 16'hff22, 16'hff24, 16'hff26, 16'hff28,
    16'hff30, 16'hff32, 16'hff34, 16'hff36,
    16'hff40, 16'hff42, 16'hff44,
    16'hff60, 16'hff62, 16'hff64,
    16'hff6c, 16'hff6e, 16'hff70, 16'hff72, 16'hff74, 16'hff76,
    16'hff88, 16'hff8a, 16'hff8c, 16'hff8e,
    16'hff98, 16'hff9a,
    16'hffa0, 16'hffa4, 16'hffaa, 16'hffac,
    16'hffae,
    16'hffb0, 16'hffb2,
    16'hffc4, 16'hffc6,
    16'hffc8, 16'hffca, 16'hffd4, 16'hffd6
  };

  // six-channel timer control and mode control have non-zero resets
  localparam logic [15:0] REG_RST_1010 = 16'h1010;
  localparam logic [15:0] REG_RST_00FF = 16'h00ff;
  localparam int SIX_CH_COMPARE_TIMER_CONTROL_IDX = 10;
  localparam int MODECON_IDX = 11;

  localparam logic [15:0] MASK_FULL = 16'hffff;
  localparam logic [15:0] MASK_7BIT = 16'h007f;
  localparam logic [15:0] MASK_8BIT = 16'h00ff;

endpackage

// File: hdl/sfb_register_bank.sv
// upper sfr register bank with gpr mirror and pec pointer ram
// assumes one cpu issuing word, byte and bit accesses on ref_clk_i
// assumes straps are settled by the first clock after reset release
//
// Overview of operation
// - all-low constant register always reads zero
// - all-high constant reads all_high_constant, writes ignored
// - word and byte access everywhere, bit access everywhere except watchdog control
// - byte write to a register clears the other byte; gpr mirror and pointer ram keep it
// - byte read returns byte, nothing altered
// - f000..f01e mirror current gpr bank
// - pec pointers survive warm reset
// - unused pointers act as plain ram
// - system config middle nibbles loaded from straps
// - watchdog control low byte from reset source
// - compare timer control resets to 1010
// - six-channel mode control resets to 00ff
// - analog port input read-only, live pins
// - port four data seven bits, reset zero
// - port eight data eight bits, reset zero
// - bit set and clear on bit-addressable
`timescale 1ns/1ps

module sfb_register_bank #(
  parameter int GPR_BANKS = 4,
  parameter int BANK_W = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire sfb_pkg::sfb_op_t op_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] bit_i,
  input wire logic [BANK_W-1:0] gpr_bank_i,
  input wire logic [7:0] startup_cfg_i,
  input wire logic [7:0] reset_source_i,
  input wire logic [15:0] analog_pins_i,
  output logic ready_o,
  output logic ack_o,
  output logic [15:0] rdata_o,
  output logic [15:0] system_configuration_o,
  output logic [15:0] watchdog_control_o,
  output logic [6:0] port_four_data_o,
  output logic [7:0] port_eight_data_o
);
  import sfb_pkg::*;

  // map: f000..f01e gpr mirror, fce0..fcfe pointer ram,
  // ff12..ffd6 registers; all else reads zero
  logic [15:0] regs [NREG];
  logic [15:0] gpr_mem [GPR_BANKS*GPR_WORDS];
  logic [15:0] pec_mem [PEC_WORDS];

  logic [7:0] cfg_meta;
  logic [7:0] cfg_sync;
  logic [7:0] src_meta;
  logic [7:0] src_sync;
  logic [15:0] pin_meta;
  logic [15:0] pin_sync;

  typedef enum logic [1:0] {
    SFB_ST_WAIT = 2'b01,
    SFB_ST_RUN = 2'b10
  } sfb_start_t;

  sfb_start_t start_state;
  logic [1:0] strap_cnt;
  logic load_pend;
  logic load_now;
  logic access;
  logic wr;
  logic rd_take;
  logic [NREG-1:0] hit;
  logic [NREG-1:0] reg_we;
  logic [NREG-1:0] bit_ok;
  logic gpr_hit;
  logic pec_hit;
  logic low_const_hit;
  logic high_const_hit;
  logic pin_hit;
  logic [BANK_W+3:0] gpr_idx;
  logic [3:0] pec_idx;
  logic [15:0] gpr_rd;
  logic [15:0] pec_rd;
  logic [15:0] reg_rd_any;
  logic [15:0] next_reg [NREG];
  logic [15:0] reg_rd [NREG];
  logic [15:0] next_rdata;

  function automatic logic [15:0] reg_reset(input int i);
    logic [15:0] v;
    v = 16'h0000;
    if (i == SIX_CH_COMPARE_TIMER_CONTROL_IDX) begin
      v = REG_RST_1010;
    end else if (i == MODECON_IDX) begin
      v = REG_RST_00FF;
    end
    return v;
  endfunction

  function automatic logic [15:0] reg_mask(input int i);
    if (i == PORT4_IDX) begin
      return MASK_7BIT;
    end
    if (i > PORT4_IDX) begin
      return MASK_8BIT;
    end
    return MASK_FULL;
  endfunction

  // watchdog control is the only entry without bit access
  function automatic logic reg_bitable(input int i);
    return i != WATCHDOG_CONTROL_IDX;
  endfunction

  // value after a write; clr_other selects sfr byte semantics
  function automatic logic [15:0] write_val(
    input logic [15:0] old,
    input sfb_op_t op,
    input logic hi,
    input logic [15:0] wd,
    input logic [3:0] b,
    input logic bitable,
    input logic clr_other
  );
    logic [15:0] v;
    v = old;
    unique case (op)
      SFB_OP_WORD: begin
        v = wd;
      end
      SFB_OP_BYTE: begin
        if (clr_other) begin
          v = hi ? {wd[7:0], 8'h00} : {8'h00, wd[7:0]};
        end else begin
          v = hi ? {wd[7:0], old[7:0]} : {old[15:8], wd[7:0]};
        end
      end
      SFB_OP_BSET: begin
        if (bitable) begin
          v = old | (16'h0001 << b);
        end
      end
      SFB_OP_BCLR: begin
        if (bitable) begin
          v = old & ~(16'h0001 << b);
        end
      end
    endcase
    return v;
  endfunction

  // byte reads return the addressed byte in the low lane
  function automatic logic [15:0] read_val(
    input logic [15:0] v,
    input sfb_op_t op,
    input logic hi
  );
    if (op == SFB_OP_BYTE) begin
      return hi ? {8'h00, v[15:8]} : {8'h00, v[7:0]};
    end
    return v;
  endfunction

  // two-stage synchronisers for pins and strap levels
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_meta <= 8'h00;
      cfg_sync <= 8'h00;
    end else if (ce_i) begin
      cfg_meta <= startup_cfg_i;
      cfg_sync <= cfg_meta;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_meta <= 8'h00;
      src_sync <= 8'h00;
    end else if (ce_i) begin
      src_meta <= reset_source_i;
      src_sync <= src_meta;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
    end else if (ce_i) begin
      pin_meta <= analog_pins_i;
      pin_sync <= pin_meta;
    end
  end

  // strap capture window after reset release
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_state <= SFB_ST_WAIT;
      strap_cnt <= 2'h0;
      ready_o <= 1'b0;
    end else if (ce_i) begin
      unique case (start_state)
        SFB_ST_WAIT: begin
          if (load_now) begin
            start_state <= SFB_ST_RUN;
            ready_o <= 1'b1;
          end else begin
            strap_cnt <= strap_cnt + 2'h1;
          end
        end
        SFB_ST_RUN: begin
          ready_o <= 1'b1;
        end
      endcase
    end
  end

  assign load_pend = (start_state == SFB_ST_WAIT);
  assign load_now = load_pend && (strap_cnt == STRAP_WAIT);

  assign access = req_i && !load_pend;
  assign wr = access && we_i;
  assign rd_take = access && !we_i;

  // word-aligned decode: bit 0 only selects a byte
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      hit[i] = access && (addr_i[15:1] == REG_OFF[i][15:1]);
    end
  end

  assign gpr_hit = access && (addr_i[15:5] == GPR_MIRROR_BASE[15:5]);
  assign pec_hit = access && (addr_i[15:5] == PEC_PTR_BASE[15:5]);
  assign gpr_idx = {gpr_bank_i, addr_i[4:1]};
  assign pec_idx = addr_i[4:1];
  assign gpr_rd = gpr_mem[gpr_idx];
  assign pec_rd = pec_mem[pec_idx];
  assign low_const_hit = (addr_i[15:1] == ALL_LOW_OFF[15:1]);
  assign high_const_hit = (addr_i[15:1] == ALL_HIGH_OFF[15:1]);
  assign pin_hit = (addr_i[15:1] == ANALOG_PORT_IN_OFF[15:1]);

  generate
    for (genvar g = 0; g < NREG; g++) begin : g_reg
      assign reg_we[g] = hit[g] && wr;
      assign bit_ok[g] = reg_bitable(g);

      // startup load outranks a cpu write in the same cycle
      always_comb begin
        next_reg[g] = regs[g];
        if (g == SYSTEM_CONFIGURATION_IDX && load_now) begin
          next_reg[g] = {4'h0, cfg_sync, 4'h0};
        end else if (g == WATCHDOG_CONTROL_IDX && load_now) begin
          next_reg[g] = {8'h00, src_sync};
        end else if (reg_we[g]) begin
          next_reg[g] = write_val(regs[g], op_i, addr_i[0], wdata_i, bit_i,
                                  bit_ok[g], 1'b1) & reg_mask(g);
        end
      end

      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          regs[g] <= reg_reset(g);
        end else if (ce_i) begin
          regs[g] <= next_reg[g];
        end
      end

      // only the addressed entry drives the read or-tree
      assign reg_rd[g] = hit[g] ? regs[g] : 16'h0000;
    end
  endgenerate

  // gpr bank storage, content undefined after power-up
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && gpr_hit && we_i) begin
      gpr_mem[gpr_idx] <= write_val(gpr_mem[gpr_idx], op_i, addr_i[0], wdata_i,
                                    bit_i, 1'b1, 1'b0);
    end
  end

  // pointer ram has no reset so warm resets keep it
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && pec_hit && we_i) begin
      pec_mem[pec_idx] <= write_val(pec_mem[pec_idx], op_i, addr_i[0], wdata_i,
                                    bit_i, 1'b1, 1'b0);
    end
  end

  // decoded hits are one-hot, so or-ing the terms selects one entry
  always_comb begin
    reg_rd_any = 16'h0000;
    for (int i = 0; i < NREG; i++) begin
      reg_rd_any = reg_rd_any | reg_rd[i];
    end
  end

  // read mux; constants ignore writes, unmapped reads zero
  always_comb begin
    logic [15:0] v;
    v = 16'h0000;
    if (low_const_hit) begin
      v = ALL_LOW_VAL;
    end else if (high_const_hit) begin
      v = ALL_HIGH_VAL;
    end else if (pin_hit) begin
      v = pin_sync;
    end else if (gpr_hit) begin
      v = gpr_rd;
    end else if (pec_hit) begin
      v = pec_rd;
    end else begin
      v = reg_rd_any;
    end
    next_rdata = read_val(v, op_i, addr_i[0]);
  end

  // acknowledge one cycle after every accepted access
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= access;
    end
  end

  // read data holds until the next accepted read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i && rd_take) begin
      rdata_o <= next_rdata;
    end
  end

  // register copies toward the surrounding logic
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_configuration_o <= 16'h0000;
    end else if (ce_i) begin
      system_configuration_o <= regs[SYSTEM_CONFIGURATION_IDX];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_control_o <= 16'h0000;
    end else if (ce_i) begin
      watchdog_control_o <= regs[WATCHDOG_CONTROL_IDX];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_four_data_o <= 7'h00;
    end else if (ce_i) begin
      port_four_data_o <= regs[PORT4_IDX][6:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_eight_data_o <= 8'h00;
    end else if (ce_i) begin
      port_eight_data_o <= regs[PORT8_IDX][7:0];
    end
  end

endmodule
